// [verilog/tsa_map.svh]
/*
 * Register offsets, field positions, reset values and timing counts of
 * the slot-switch rate, alignment and block-programming logic.
 * Assumes a 10 MHz core clock and word-wide AHB-Lite access.
 */
`ifndef TSA_MAP_SVH
`define TSA_MAP_SVH

// register indices; byte address is four times the index
`define TSA_IDX_CTRL        13'h0000
`define TSA_IDX_FAR         13'h0001
`define TSA_IDX_DOS0        13'h0002
`define TSA_IDX_DOS7        13'h0009
`define TSA_IDX_OUTPUT_ADVANCE_REGS        13'h000A
`define TSA_IDX_FOR3        13'h000D
`define TSA_IDX_W           14

// control register fields
`define TSA_CTRL_RATE_LSB   0
`define TSA_CTRL_SFE_BIT    10
`define TSA_CTRL_GO_BIT     11
`define TSA_CTRL_MODE_BIT   12
`define TSA_CTRL_PAT_LSB    13
`define TSA_CTRL_RESET      16'h0000

// frame alignment register fields
`define TSA_FAR_OFS_LSB     0
`define TSA_FAR_DONE_BIT    10
`define TSA_FAR_SEL_LSB     11
`define TSA_FAR_RESET       16'h0000

// offset fields
`define TSA_DOS_FIELD_W     4
`define TSA_DOS_PER_REG     4
`define TSA_DOS_MAX         4'h9
`define TSA_FOR_FIELD_W     2
`define TSA_FOR_PER_REG     8
`define TSA_OFS_RESET       16'h0000

// output advance step and limit in ns
`define TSA_ADV_STEP_NS     15
`define TSA_ADV_MAX_NS      45

// frame timing
`define TSA_CLK_NS          100
`define TSA_FRAME_NS        125000
`define TSA_FRAME_CYC       (`TSA_FRAME_NS / `TSA_CLK_NS)
`define TSA_EVAL_FRAMES     2

`endif

// [verilog/tsa_pkg.sv]
/*
 * Types of the slot-switch rate, alignment and block-programming logic.
 * Assumes tsa_map.svh supplies all numbers.
 */
package tsa_pkg;

   // data rate select codes
   typedef enum logic [2:0] {
      RATE_8M, RATE_16M, RATE_4M8M, RATE_16M8M,
      RATE_4M, RATE_2M4M, RATE_2M, RATE_RSVD
   } tsa_rate_t;

   // per-stream line rate
   typedef enum logic [2:0] {
      LINE_OFF, LINE_2M, LINE_4M, LINE_8M, LINE_16M
   } tsa_line_t;

   // frame evaluation sequence
   typedef enum logic [1:0] {
      EV_IDLE, EV_MEAS, EV_WAIT, EV_DONE
   } tsa_eval_t;

   // control register image
   typedef struct packed {
      logic [2:0] pattern;
      logic       block_prog_mode;
      logic       block_prog_go;
      logic       start_frame_eval;
      logic [6:0] spare;
      tsa_rate_t  rate;
   } tsa_ctrl_t;

   // registered AHB address phase
   typedef struct packed {
      logic        write;
      logic [13:0] index;
   } tsa_req_t;

endpackage

// [verilog/tsa_top.sv]
/*
 * Rate mode, frame alignment evaluation, per-stream offsets, memory
 * decode and connection memory block programming of a slot switch.
 * Assumes one 10 MHz clock, AHB-Lite single word transfers, and a frame
 * pulse and evaluation inputs that are synchronous to the clock.
 */
// The AHB-Lite slave port and the register addresses were left to the implementer.
// Function
// RULE_01: rate code 101 runs streams 0-15 at 2M, 16-31 at 4M.
// RULE_02: mixed 2/4 mode allows switching across the two rate groups.
// RULE_03: rate code 110 runs 32 streams of 32 channels each.
// RULE_04: five-bit field picks one of 32 frame evaluation inputs.
// RULE_05: offset is measured in internal master clock periods.
// RULE_06: start bit low a frame, evaluation starts on its rise.
// RULE_07: two frames later done flag rises, offset in bits 0-9.
// RULE_08: software returns start bit low before another measurement.
// RULE_09: selected input falling edge timed against frame pulse fall.
// RULE_10: input offset applies only to streams faster than 2M.
// RULE_11: eight input offset registers, four streams each.
// RULE_12: input delay up to 4.5 periods in half-period steps.
// RULE_13: output advance up to 45 ns in 15 ns steps, some modes.
// RULE_14: per-stream output advance fields in output offset registers.
// RULE_15: memory space: bits 12-8 stream, bits 7-0 channel.
// RULE_16: block load writes pattern bits 13-15 everywhere, two frames.
// RULE_17: mode bit arms block load, go bit starts it.
// RULE_18: block load writes zeros to bits 0-12.
// RULE_19: go bit clears itself when block load finishes.
// RULE_20: space select low decodes control and offset registers.
// RULE_21: write counter resets on each frame pulse.
// RULE_22: channels beyond the stream's rate carry nothing.
// RULE_23: start bit sampled at frame boundaries.
`timescale 1ns/1ps
`include "tsa_map.svh"

module tsa_top (
   // clock and reset
   input  wire logic          CLOCK,
   input  wire logic          RESETN,
   // AHB-Lite slave
   input  wire logic          HSEL,
   input  wire logic [31:0]   HADDR,
   input  wire logic [1:0]    HTRANS,
   input  wire logic          HWRITE,
   input  wire logic [2:0]    HSIZE,
   input  wire logic [31:0]   HWDATA,
   input  wire logic          HREADY,
   output logic      [31:0]   HRDATA,
   output logic               HREADYOUT,
   output logic               HRESP,
   // frame timing
   input  wire logic          FRAME_PULSE_IN_N,
   input  wire logic [31:0]   FRAME_EVAL_INPUT,
   output logic      [10:0]   WRITE_COUNT,
   // per-stream settings
   output logic      [95:0]   STREAM_RATE,
   output logic      [127:0]  IN_DELAY_HALF,
   output logic      [63:0]   OUT_ADVANCE,
   output logic               BLOCK_BUSY
);

   localparam int NSTR = 32;
   localparam int NCH  = 256;
   localparam logic [10:0] FRAME_LAST = 11'(`TSA_FRAME_CYC - 1);

   ////////////////////////////////////////////////////////////////////
   // state
   tsa_pkg::tsa_ctrl_t  ctrl_reg;
   logic [4:0]          eval_sel_reg;
   logic                eval_done_reg;
   logic [9:0]          eval_ofs_reg;
   logic [15:0]         dos_reg [0:7];
   logic [15:0]         for_reg [0:3];
   logic [15:0]         cm_mem [0:NSTR*NCH-1];
   tsa_pkg::tsa_req_t   req_reg;
   logic                pend_reg;
   logic [31:0]         hrdata_reg;
   logic                hreadyout_reg;
   logic [10:0]         wr_cnt_reg;
   logic                fp_prev_reg;
   logic                fe_prev_reg;
   logic [1:0]          sfe_hist_reg;
   tsa_pkg::tsa_eval_t  ev_reg;
   logic                ev_caught_reg;
   logic                bp_run_reg;
   logic [4:0]          bp_str_reg;
   logic [95:0]         rate_out_reg;
   logic [127:0]        dly_out_reg;
   logic [63:0]         adv_out_reg;

   ////////////////////////////////////////////////////////////////////
   // per-stream line rate for each rate code
   function automatic tsa_pkg::tsa_line_t line_of(
         input tsa_pkg::tsa_rate_t r, input logic [4:0] s);
      tsa_pkg::tsa_line_t l;
      l = tsa_pkg::LINE_OFF;
      unique case (r)
         tsa_pkg::RATE_8M:    l = tsa_pkg::LINE_8M;
         tsa_pkg::RATE_16M:
            l = (s < 5'd16) ? tsa_pkg::LINE_16M : tsa_pkg::LINE_OFF;
         tsa_pkg::RATE_4M8M:
            l = (s < 5'd16) ? tsa_pkg::LINE_4M : tsa_pkg::LINE_8M;
         tsa_pkg::RATE_16M8M:
            l = (s < 5'd12) ? tsa_pkg::LINE_16M :
                (s < 5'd20) ? tsa_pkg::LINE_8M : tsa_pkg::LINE_OFF;
         tsa_pkg::RATE_4M:    l = tsa_pkg::LINE_4M;
         tsa_pkg::RATE_2M4M:                                   // RULE_01
            l = (s < 5'd16) ? tsa_pkg::LINE_2M : tsa_pkg::LINE_4M;
         tsa_pkg::RATE_2M:    l = tsa_pkg::LINE_2M;           // RULE_03
         tsa_pkg::RATE_RSVD:  l = tsa_pkg::LINE_OFF;
      endcase
      return l;
   endfunction

   // channels carried by a line: 32 per 2 Mbps of rate
   function automatic logic [8:0] chans_of(input tsa_pkg::tsa_line_t l);
      logic [8:0] n;
      n = 9'd0;
      unique case (l)
         tsa_pkg::LINE_2M:  n = 9'd32;
         tsa_pkg::LINE_4M:  n = 9'd64;
         tsa_pkg::LINE_8M:  n = 9'd128;
         tsa_pkg::LINE_16M: n = 9'd256;
         default:           n = 9'd0;
      endcase
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // bus request decode
   logic        accept;
   logic [13:0] acc_index;
   logic        mem_hit;
   logic [4:0]  mem_str;
   logic [7:0]  mem_ch;
   logic        ch_ok;

   assign accept    = HSEL & HTRANS[1] & HREADY;
   assign acc_index = HADDR[15:2];
   assign mem_hit   = req_reg.index[13];                      // RULE_20
   assign mem_str   = req_reg.index[12:8];                    // RULE_15
   assign mem_ch    = req_reg.index[7:0];                     // RULE_15
   // cross-group slots stay addressable: either rate may feed the other
   assign ch_ok     = {1'b0, mem_ch} <
                      chans_of(line_of(ctrl_reg.rate, mem_str)); // RULE_22

   // address phase captured; one wait state, then the answer
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         pend_reg      <= 1'b0;
         req_reg       <= '0;
         hreadyout_reg <= 1'b1;
      end else if (accept && hreadyout_reg) begin
         pend_reg      <= 1'b1;
         req_reg       <= '{write: HWRITE, index: acc_index};
         hreadyout_reg <= 1'b0;
      end else begin
         pend_reg      <= 1'b0;
         hreadyout_reg <= 1'b1;
      end
   end

   logic wr_en;
   assign wr_en = pend_reg & req_reg.write;

   ////////////////////////////////////////////////////////////////////
   // read mux, registered in the wait state
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (pend_reg && !req_reg.write) begin
         hrdata_reg <= 32'h0000_0000;
         if (mem_hit) begin
            if (ch_ok)
               hrdata_reg <= {16'h0000, cm_mem[req_reg.index[12:0]]};
         end else if (req_reg.index == `TSA_IDX_CTRL) begin
            hrdata_reg <= {16'h0000, ctrl_reg};
         end else if (req_reg.index == `TSA_IDX_FAR) begin
            hrdata_reg <= {16'h0000, eval_sel_reg, eval_done_reg,
                           eval_ofs_reg};                     // RULE_07
         end else if (req_reg.index >= `TSA_IDX_DOS0 &&
                      req_reg.index <= `TSA_IDX_DOS7) begin
            hrdata_reg <= {16'h0000,
                           dos_reg[3'(req_reg.index - `TSA_IDX_DOS0)]};
         end else if (req_reg.index >= `TSA_IDX_OUTPUT_ADVANCE_REGS &&
                      req_reg.index <= `TSA_IDX_FOR3) begin
            hrdata_reg <= {16'h0000,
                           for_reg[2'(req_reg.index - `TSA_IDX_OUTPUT_ADVANCE_REGS)]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control register; a software write wins over the self-clear of go
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_reg <= tsa_pkg::tsa_ctrl_t'(`TSA_CTRL_RESET);
      end else if (wr_en && req_reg.index == `TSA_IDX_CTRL) begin
         ctrl_reg <= tsa_pkg::tsa_ctrl_t'(HWDATA[15:0]);
      end else if (bp_run_reg && bp_str_reg == 5'(NSTR - 1)) begin
         ctrl_reg.block_prog_go <= 1'b0;                      // RULE_19
      end
   end

   // offset registers and evaluation select
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         eval_sel_reg <= 5'(`TSA_FAR_RESET >> `TSA_FAR_SEL_LSB);
         for (int i = 0; i < 8; i++)
            dos_reg[i] <= `TSA_OFS_RESET;
         for (int i = 0; i < 4; i++)
            for_reg[i] <= `TSA_OFS_RESET;
      end else if (wr_en && !mem_hit) begin
         if (req_reg.index == `TSA_IDX_FAR)
            eval_sel_reg <= HWDATA[`TSA_FAR_SEL_LSB +: 5];    // RULE_04
         if (req_reg.index >= `TSA_IDX_DOS0 &&
             req_reg.index <= `TSA_IDX_DOS7)
            dos_reg[3'(req_reg.index - `TSA_IDX_DOS0)] <=
               HWDATA[15:0];                                  // RULE_11
         if (req_reg.index >= `TSA_IDX_OUTPUT_ADVANCE_REGS &&
             req_reg.index <= `TSA_IDX_FOR3)
            for_reg[2'(req_reg.index - `TSA_IDX_OUTPUT_ADVANCE_REGS)] <=
               HWDATA[15:0];                                  // RULE_14
      end
   end

   ////////////////////////////////////////////////////////////////////
   // connection memory; software writes that arrive while a block
   // load runs are dropped, so the load never races a single-slot update
   always_ff @(posedge CLOCK) begin
      if (bp_run_reg) begin
         for (int c = 0; c < NCH; c++)
            cm_mem[{bp_str_reg, 8'(c)}] <=
               {ctrl_reg.pattern, 13'h0000};          // RULE_16 RULE_18
      end else if (wr_en && mem_hit && ch_ok) begin
         cm_mem[req_reg.index[12:0]] <= HWDATA[15:0];         // RULE_15
      end
   end

   // block load walks one stream per clock, far inside two frames
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         bp_run_reg <= 1'b0;
         bp_str_reg <= 5'h00;
      end else if (bp_run_reg) begin
         bp_str_reg <= bp_str_reg + 5'h01;
         if (bp_str_reg == 5'(NSTR - 1))
            bp_run_reg <= 1'b0;
      end else if (ctrl_reg.block_prog_mode &&
                   ctrl_reg.block_prog_go) begin              // RULE_17
         bp_run_reg <= 1'b1;
         bp_str_reg <= 5'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frame pulse edge and write counter
   logic frame_fall;
   logic eval_fall;
   assign frame_fall = fp_prev_reg & ~FRAME_PULSE_IN_N;
   assign eval_fall  = fe_prev_reg & ~FRAME_EVAL_INPUT[eval_sel_reg];

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         fp_prev_reg <= 1'b1;
         fe_prev_reg <= 1'b1;
         wr_cnt_reg  <= 11'h000;
      end else begin
         fp_prev_reg <= FRAME_PULSE_IN_N;
         fe_prev_reg <= FRAME_EVAL_INPUT[eval_sel_reg];       // RULE_04
         if (frame_fall)
            wr_cnt_reg <= 11'h000;                            // RULE_21
         else if (wr_cnt_reg != FRAME_LAST)
            wr_cnt_reg <= wr_cnt_reg + 11'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frame evaluation; start bit only seen at frame edges, so a rise
   // counts only after two edges, a whole frame, found it low
   logic ev_start;
   assign ev_start = frame_fall & ctrl_reg.start_frame_eval &
                     (sfe_hist_reg == 2'b00);         // RULE_06 RULE_23

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN)
         sfe_hist_reg <= 2'b11;
      else if (frame_fall)
         sfe_hist_reg <= {sfe_hist_reg[0], ctrl_reg.start_frame_eval};
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ev_reg        <= tsa_pkg::EV_IDLE;
         ev_caught_reg <= 1'b0;
         eval_ofs_reg  <= 10'h000;
         eval_done_reg <= 1'b0;
      end else begin
         unique case (ev_reg)
            tsa_pkg::EV_IDLE: begin
               if (ev_start) begin
                  ev_reg        <= tsa_pkg::EV_MEAS;
                  ev_caught_reg <= 1'b0;
                  eval_done_reg <= 1'b0;
               end
            end
            tsa_pkg::EV_MEAS: begin
               // offset counted in core clocks from the frame fall
               if (eval_fall && !ev_caught_reg) begin
                  eval_ofs_reg  <= wr_cnt_reg[9:0];   // RULE_05 RULE_09
                  ev_caught_reg <= 1'b1;
               end
               if (frame_fall)
                  ev_reg <= tsa_pkg::EV_WAIT;
            end
            tsa_pkg::EV_WAIT: begin
               if (frame_fall) begin
                  ev_reg        <= tsa_pkg::EV_DONE;
                  eval_done_reg <= 1'b1;                      // RULE_07
               end
            end
            tsa_pkg::EV_DONE: begin
               // a fresh run needs the start bit dropped first
               if (!ctrl_reg.start_frame_eval)
                  ev_reg <= tsa_pkg::EV_IDLE;                 // RULE_08
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // per-stream effective rate, input delay and output advance
   logic adv_mode;
   assign adv_mode = ctrl_reg.rate == tsa_pkg::RATE_8M ||
                     ctrl_reg.rate == tsa_pkg::RATE_16M ||
                     ctrl_reg.rate == tsa_pkg::RATE_4M8M ||
                     ctrl_reg.rate == tsa_pkg::RATE_16M8M;    // RULE_13

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         rate_out_reg <= '0;
         dly_out_reg  <= '0;
         adv_out_reg  <= '0;
      end else begin
         for (int s = 0; s < NSTR; s++) begin
            logic [3:0] d;
            tsa_pkg::tsa_line_t ln;
            d  = dos_reg[s / `TSA_DOS_PER_REG]
                 [(s % `TSA_DOS_PER_REG) * `TSA_DOS_FIELD_W +: 4];
            ln = line_of(ctrl_reg.rate, 5'(s));
            rate_out_reg[s*3 +: 3] <= ln;             // RULE_01 RULE_02
            if (ln == tsa_pkg::LINE_2M || ln == tsa_pkg::LINE_OFF)
               dly_out_reg[s*4 +: 4] <= 4'h0;                 // RULE_10
            else if (d > `TSA_DOS_MAX)
               dly_out_reg[s*4 +: 4] <= `TSA_DOS_MAX;         // RULE_12
            else
               dly_out_reg[s*4 +: 4] <= d;                    // RULE_12
            adv_out_reg[s*2 +: 2] <= adv_mode ?
               for_reg[s / `TSA_FOR_PER_REG]
                      [(s % `TSA_FOR_PER_REG) * 2 +: 2] :
               2'b00;                                 // RULE_13 RULE_14
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops except HRESP, which is tied low
   assign HRDATA        = hrdata_reg;
   assign HREADYOUT     = hreadyout_reg;
   assign HRESP         = 1'b0;
   assign WRITE_COUNT   = wr_cnt_reg;
   assign STREAM_RATE   = rate_out_reg;
   assign IN_DELAY_HALF = dly_out_reg;
   assign OUT_ADVANCE   = adv_out_reg;
   assign BLOCK_BUSY    = bp_run_reg;

endmodule

// [tb/tsa_top_asserts.sv]
/*
 * Port checks of tsa_top.
 * Assumes one clock and the active-low reset.
 */
`timescale 1ns/1ps

module tsa_top_chk (
   // clock and reset
   input wire logic          CLOCK,
   input wire logic          RESETN,
   // bus
   input wire logic          HSEL,
   input wire logic [1:0]    HTRANS,
   input wire logic          HREADY,
   input wire logic [31:0]   HRDATA,
   input wire logic          HREADYOUT,
   input wire logic          HRESP,
   // frame timing
   input wire logic          FRAME_PULSE_IN_N,
   input wire logic [10:0]   WRITE_COUNT,
   // per-stream settings
   input wire logic [95:0]   STREAM_RATE,
   input wire logic [127:0]  IN_DELAY_HALF,
   input wire logic [63:0]   OUT_ADVANCE,
   input wire logic          BLOCK_BUSY
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESETN);

   ////////////////////////////////////////////////////////////////////////
   logic [5:0] busy_run_reg;
   logic       slow_dly, big_dly, has_2m, has_fast;

   // cycles of the current block load
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN)
         busy_run_reg <= 6'h0;
      else if (BLOCK_BUSY)
         busy_run_reg <= busy_run_reg + 6'h1;
      else
         busy_run_reg <= 6'h0;
   end

   // flags covering all 32 streams
   always_comb begin
      slow_dly = 1'b0;
      big_dly  = 1'b0;
      has_2m   = 1'b0;
      has_fast = 1'b0;
      for (int s = 0; s < 32; s++) begin
         if (STREAM_RATE[3*s +: 3] <= 3'h1 && IN_DELAY_HALF[4*s +: 4] != 4'h0)
            slow_dly = 1'b1;
         if (IN_DELAY_HALF[4*s +: 4] > 4'h9) big_dly = 1'b1;
         if (STREAM_RATE[3*s +: 3] == 3'h1) has_2m = 1'b1;
         if (STREAM_RATE[3*s +: 3] >= 3'h3) has_fast = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence take_seq;
      HSEL && HTRANS[1] && HREADY && HREADYOUT;
   endsequence
   sequence wait_seq;
      !HREADYOUT ##1 HREADYOUT;
   endsequence

   wait_state_a: assert property (take_seq |=> wait_seq)
      else $error("wait state missing");
   okay_resp_a: assert property (HRESP == 1'b0)
      else $error("response not okay");
   rdata_upper_a: assert property (HRDATA[31:16] == 16'h0)
      else $error("read data upper half set");
   count_clear_a: assert property (
      $fell(FRAME_PULSE_IN_N) |=> WRITE_COUNT == 11'h0)
      else $error("count not cleared");
   count_step_a: assert property (
      FRAME_PULSE_IN_N && $past(FRAME_PULSE_IN_N) && WRITE_COUNT < 11'd1249
      |=> WRITE_COUNT == $past(WRITE_COUNT) + 11'h1)
      else $error("count did not step");
   count_limit_a: assert property (WRITE_COUNT <= 11'd1249)
      else $error("count beyond frame");
   busy_span_a: assert property (
      $fell(BLOCK_BUSY) |-> busy_run_reg == 6'd32)
      else $error("block load length");
   busy_max_a: assert property (
      BLOCK_BUSY |-> busy_run_reg < 6'd32)
      else $error("block load too long");
   dly_slow_a: assert property (!slow_dly)
      else $error("delay on slow stream");
   dly_limit_a: assert property (!big_dly)
      else $error("delay above nine");
   adv_mode_a: assert property (
      OUT_ADVANCE != 64'h0 |-> has_fast && !has_2m)
      else $error("advance outside fast modes");
endmodule

bind tsa_top tsa_top_chk u_chk (
   .CLOCK(CLOCK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS),
   .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .FRAME_PULSE_IN_N(FRAME_PULSE_IN_N), .WRITE_COUNT(WRITE_COUNT),
   .STREAM_RATE(STREAM_RATE), .IN_DELAY_HALF(IN_DELAY_HALF),
   .OUT_ADVANCE(OUT_ADVANCE), .BLOCK_BUSY(BLOCK_BUSY)
);

// [tb/tsa_backplane.sv]
/*
 * Backplane: frame pulse and 32 evaluation inputs.
 * Assumes the switch clock; input k falls 20+3k cycles into each frame.
 */
`timescale 1ns/1ps

module tsa_backplane #(
   parameter int FRAME_CYC = 1250
) (
   // clock and reset
   input wire logic          clock,
   input wire logic          resetn,
   // frame timing toward the switch
   output logic              frame_n,
   output logic [31:0]       eval_in
);
   logic [10:0] cyc_reg;

   // position in the frame
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         cyc_reg <= 11'h0;
      else if (cyc_reg == 11'(FRAME_CYC - 1))
         cyc_reg <= 11'h0;
      else
         cyc_reg <= cyc_reg + 11'h1;
   end

   // one-cycle frame start pulse
   assign frame_n = (cyc_reg != 11'h0);

   // staggered falls, one offset per select
   always_comb begin
      for (int k = 0; k < 32; k++)
         eval_in[k] = !(cyc_reg >= 11'(20 + 3*k) && cyc_reg < 11'd700);
   end
endmodule

// [tb/tsa_top_bench.sv]
/*
 * Self-checking bench of tsa_top.
 * Assumes tsa_backplane as the far side.
 */
`timescale 1ns/1ps
`include "tsa_map.svh"

module tsa_top_bench;
   logic          clock, resetn, hwrite, hreadyout, hresp, busy, frame_n;
   logic          dphase, dread;
   logic [1:0]    htrans;
   logic [31:0]   haddr, hwdata, hrdata, eval_in, d;
   logic [10:0]   wcount;
   logic [95:0]   srate;
   logic [127:0]  idelay, e;
   logic [63:0]   oadv;
   logic [13:0]   a;
   logic [3:0]    f;
   logic [31:0]   exp_q[$];
   logic [15:0]   dv[8], fv[4];
   int            err_total, tests_run, seed, n;
   int            mc[5] = '{6, 6, 5, 5, 5};
   int            ms[5] = '{5, 5, 20, 20, 3};
   int            mch[5] = '{31, 32, 63, 64, 32};

   tsa_top i_dut (
      .CLOCK(clock), .RESETN(resetn), .HSEL(1'b1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .FRAME_PULSE_IN_N(frame_n), .FRAME_EVAL_INPUT(eval_in),
      .WRITE_COUNT(wcount), .STREAM_RATE(srate), .IN_DELAY_HALF(idelay),
      .OUT_ADVANCE(oadv), .BLOCK_BUSY(busy));

   tsa_backplane #(.FRAME_CYC(`TSA_FRAME_CYC)) i_far (
      .clock(clock), .resetn(resetn), .frame_n(frame_n), .eval_in(eval_in));

   ////////////////////////////////////////////////////////////////////////
   // expected line rate of stream s under rate code c
   function automatic logic [2:0] rate_of(input logic [2:0] c, input int s);
      case (c)
         3'h0: return 3'h3;
         3'h1: return (s < 16) ? 3'h4 : 3'h0;
         3'h2: return (s < 16) ? 3'h2 : 3'h3;
         3'h3: return (s < 12) ? 3'h4 : ((s < 20) ? 3'h3 : 3'h0);
         3'h4: return 3'h2;
         3'h5: return (s < 16) ? 3'h1 : 3'h2;
         3'h6: return 3'h1;
         default: return 3'h0;
      endcase
   endfunction

   // channels at a line rate
   function automatic int chans(input logic [2:0] r);
      return (r == 3'h0) ? 0 : (16 << r);
   endfunction

   task automatic chk(input logic [127:0] got, input logic [127:0] want);
      tests_run++;
      if (got !== want) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, got, want);
      end
   endtask

   // single transfer, called just after a rising edge
   task automatic xfer(input logic w, input logic [13:0] idx,
                       input logic [31:0] wd);
      htrans <= 2'h2;
      haddr  <= {16'h0, idx, 2'h0};
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
   endtask

   task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
      xfer(1'b1, idx, wd);
   endtask

   // expected read value queued for the monitor
   task automatic rd(input logic [13:0] idx, input logic [31:0] want);
      exp_q.push_back(want);
      xfer(1'b0, idx, 32'h0);
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge clock);
   endtask

   task automatic falls(input int k);
      repeat (k) @(negedge frame_n);
      @(posedge clock);
   endtask

   task automatic end_of_test;
      $display("counts: %0d checks %0d errors", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // monitor: read data taken as the data phase ends
   always @(posedge clock) begin
      if (dphase && hreadyout === 1'b1) begin
         if (dread && exp_q.size() > 0)
            chk(hrdata, exp_q.pop_front());
         dphase = 1'b0;
      end
      if (htrans[1] && hreadyout === 1'b1) begin
         dphase = 1'b1;
         dread = !hwrite;
      end
   end

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // tests take about five frames
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      end_of_test();
   end

   initial begin
      seed = 32'hdad8_4145;
      {htrans, haddr, hwrite, hwdata, dphase, dread} = '0;
      resetn = 1'b0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rd(`TSA_IDX_CTRL, 32'h0);
      rd(`TSA_IDX_FAR, 32'h0);
      rd(`TSA_IDX_DOS7, 32'h0);
      wr(14'h000e, 32'h0000_ffff);
      rd(14'h000e, 32'h0);
      $display("test reset done");
      // offsets, then every rate code except the reserved code 7
      for (int k = 0; k < 8; k++) begin
         dv[k] = 16'($random(seed));
         wr(14'(`TSA_IDX_DOS0 + k), {16'h0, dv[k]});
      end
      for (int k = 0; k < 4; k++) begin
         fv[k] = 16'($random(seed));
         wr(14'(`TSA_IDX_OUTPUT_ADVANCE_REGS + k), {16'h0, fv[k]});
      end
      for (int c = 0; c < 7; c++) begin
         wr(`TSA_IDX_CTRL, 32'(c));
         idle(3);
         e = '0;
         for (int s = 0; s < 32; s++) e[3*s +: 3] = rate_of(c[2:0], s);
         chk(srate, e);
         e = '0;
         for (int s = 0; s < 32; s++) begin
            f = dv[s/4][4*(s%4) +: 4];
            if (rate_of(c[2:0], s) > 3'h1) e[4*s +: 4] = (f > 4'h9) ? 4'h9 : f;
         end
         chk(idelay, e);
         chk(oadv, (c < 4) ? {fv[3], fv[2], fv[1], fv[0]} : 64'h0);
      end
      $display("test rates done");
      for (int i = 0; i < 5; i++) begin
         wr(`TSA_IDX_CTRL, 32'(mc[i]));
         d = $random(seed) & 32'h0000_ffff;
         a = {1'b1, 5'(ms[i]), 8'(mch[i])};
         wr(a, d);
         n = chans(rate_of(3'(mc[i]), ms[i]));
         rd(a, (mch[i] < n) ? d : 32'h0);
      end
      $display("test memory done");
      wr(`TSA_IDX_CTRL, 32'h0000_9006);
      wr(`TSA_IDX_CTRL, 32'h0000_b806);
      for (n = 0; busy !== 1'b1 && n < 20; n++) @(posedge clock);
      for (n = 0; busy === 1'b1 && n < 40; n++) @(posedge clock);
      chk(n, 32);
      rd(`TSA_IDX_CTRL, 32'h0000_b006);
      rd({1'b1, 5'h5, 8'h1f}, 32'h0000_a000);
      wr(`TSA_IDX_CTRL, 32'h0000_0006);
      $display("test block load done");
      wr(`TSA_IDX_FAR, 32'h0000_3800);
      falls(2);
      wr(`TSA_IDX_CTRL, 32'h0000_0406);
      rd(`TSA_IDX_FAR, 32'h0000_3800);
      falls(3);
      idle(4);
      rd(`TSA_IDX_FAR, 32'h0000_3c28);
      idle(3);
      chk(exp_q.size(), 0);
      $display("test evaluation done");
      end_of_test();
   end
endmodule
